//--- rtl/bfd_cfg.svh
// constants of the branch and flag clear decoder
`ifndef BFD_CFG_SVH
`define BFD_CFG_SVH

`define BFD_OP_CALL_MASK 16'hF0FF
`define BFD_OP_CALL_VAL 16'h0003
`define BFD_OP_FAR_MASK 16'hF0FF
`define BFD_OP_FAR_VAL 16'h0023
`define BFD_OP_BYTE_MASK 16'hFF00
`define BFD_OP_BT_VAL 16'h8900
`define BFD_OP_BF_VAL 16'h8B00
`define BFD_OP_BTS_VAL 16'h8D00
`define BFD_OP_BFS_VAL 16'h8F00
`define BFD_OP_NIB_MASK 16'hF000
`define BFD_OP_BRA_VAL 16'hA000
`define BFD_OP_BSR_VAL 16'hB000
`define BFD_OP_FULL_MASK 16'hFFFF
`define BFD_OP_ACCUMULATOR_CLEAR_VAL 16'h0028
`define BFD_OP_SATURATION_FLAG_CLEAR_VAL 16'h0048
`define BFD_OP_TEST_FLAG_CLEAR_VAL 16'h0008

`define BFD_PC_AHEAD 32'h0000_0004
`define BFD_PC_STEP 32'h0000_0002
`define BFD_ZERO32 32'h0000_0000

`define BFD_REG_CTRL 8'h00
`define BFD_REG_STATUS 8'h04
`define BFD_REG_PR 8'h08
`define BFD_REG_ACC_HI 8'h0C
`define BFD_REG_ACC_LO 8'h10
`define BFD_REG_SLOT_CNT 8'h14

`define BFD_CTRL_RESET 1'h1
`define BFD_BIT_ENABLE 0
`define BFD_BIT_TEST 0
`define BFD_BIT_SAT 1
`define BFD_BIT_SLOT 2
`define BFD_BIT_HOLD 3
`define BFD_BIT_CALL 4

`define BFD_RESP_OKAY 2'h0
`define BFD_RESP_SLVERR 2'h2

`endif

//--- rtl/bfd_pkg.sv
// types shared by the branch and flag clear decoder
package bfd_pkg;

   typedef enum logic [0:0] {
      BFD_IDLE = 1'b0,
      BFD_CALL = 1'b1
   } bfd_state_type;

   typedef struct packed {
      logic [15:0] word;
      logic [31:0] pc;
      logic [31:0] selected_general_register;
   } bfd_issue_type;

   typedef struct packed {
      logic [31:0] fetch_pc;
      logic redirect;
      logic retire;
      logic slot_illegal;
   } bfd_flow_type;

endpackage

//--- rtl/bfd_op_match.sv
// one opcode pattern comparator
`timescale 1ns/1ns
module bfd_op_match #(
   parameter logic [15:0] MASK = 16'hFFFF,
   parameter logic [15:0] VALUE = 16'h0000
) (
   input wire logic [15:0] word,
   output logic hit
);
   assign hit = ((word & MASK) == VALUE);
endmodule

//--- rtl/bfd_target.sv
// branch target adder for register and displacement forms
`timescale 1ns/1ns
`include "bfd_cfg.svh"
module bfd_target (
   input wire logic [31:0] pc,
   input wire logic use_reg,
   input wire logic [7:0] disp,
   input wire logic [31:0] reg_value,
   output logic [31:0] target
);
   logic [31:0] offset;
   // displacement counts half words, so it is doubled after extension
   assign offset = use_reg ? reg_value : {{23{disp[7]}}, disp, 1'b0};
   assign target = pc + `BFD_PC_AHEAD + offset;
endmodule

//--- rtl/bfd_core.sv
// branch and flag clear decode and execute with its register slave
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "bfd_cfg.svh"
module bfd_core import bfd_pkg::*; #(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire bfd_issue_type issue,
   input wire logic issue_valid,
   output logic issue_ready,
   output bfd_flow_type flow,
   output logic int_hold,
   output logic [31:0] procedure_return_reg,
   output logic [31:0] accumulator_high,
   output logic [31:0] accumulator_low,
   output logic test_flag,
   output logic saturation_flag
);

   localparam int N_OP = 11;
   localparam int OP_CALL = 0;
   localparam int OP_BT = 1;
   localparam int OP_BTS = 2;
   localparam int OP_ACCUMULATOR_CLEAR = 3;
   localparam int OP_SATURATION_FLAG_CLEAR = 4;
   localparam int OP_TEST_FLAG_CLEAR = 5;
   localparam logic [15:0] OP_MASK [N_OP] = '{
      `BFD_OP_CALL_MASK, `BFD_OP_BYTE_MASK, `BFD_OP_BYTE_MASK, `BFD_OP_FULL_MASK,
      `BFD_OP_FULL_MASK, `BFD_OP_FULL_MASK, `BFD_OP_FAR_MASK, `BFD_OP_BYTE_MASK,
      `BFD_OP_BYTE_MASK, `BFD_OP_NIB_MASK, `BFD_OP_NIB_MASK};
   localparam logic [15:0] OP_VAL [N_OP] = '{
      `BFD_OP_CALL_VAL, `BFD_OP_BT_VAL, `BFD_OP_BTS_VAL, `BFD_OP_ACCUMULATOR_CLEAR_VAL,
      `BFD_OP_SATURATION_FLAG_CLEAR_VAL, `BFD_OP_TEST_FLAG_CLEAR_VAL, `BFD_OP_FAR_VAL, `BFD_OP_BF_VAL,
      `BFD_OP_BFS_VAL, `BFD_OP_BRA_VAL, `BFD_OP_BSR_VAL};
   // entries that count as branches when they sit in a delay slot
   localparam logic [N_OP-1:0] BRANCH_SEL = 11'h7C7;

   bfd_state_type state, next_state;
   logic [N_OP-1:0] hit;
   logic take, is_branch, slot_bad, exec, bt_taken, bts_taken, slot_pending;
   logic [31:0] slot_target, call_target, call_pc, target, slot_count;
   logic ctrl_enable, wr_commit, wr_known, sw_status, sw_acc_hi, sw_acc_lo, rd_known;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] wdata_q, rd_value;
   logic [3:0] wstrb_q;

   ////////////////////////////////////////////////////////////////////////////
   // decode

   genvar gi;
   generate
      for (gi = 0; gi < N_OP; gi++) begin : g_op
         bfd_op_match #(
            .MASK(OP_MASK[gi]),
            .VALUE(OP_VAL[gi])
         ) u_match (
            .word(issue.word),
            .hit(hit[gi])
         );
      end
   endgenerate

   bfd_target u_target (
      .pc(issue.pc),
      .use_reg(hit[OP_CALL]),
      .disp(issue.word[7:0]),
      .reg_value(issue.selected_general_register),
      .target(target)
   );

   assign take = issue_valid && issue_ready;
   assign is_branch = |(hit & BRANCH_SEL);
   assign slot_bad = take && slot_pending && is_branch;
   assign exec = take && !slot_bad;
   assign bt_taken = exec && hit[OP_BT] && test_flag;
   assign bts_taken = exec && hit[OP_BTS] && test_flag;

   ////////////////////////////////////////////////////////////////////////////
   // sequencing: the register call takes a second state

   always_comb begin
      next_state = state;
      case (state)
         BFD_IDLE: if (exec && hit[OP_CALL]) next_state = BFD_CALL;
         BFD_CALL: next_state = BFD_IDLE;
         default: next_state = BFD_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= BFD_IDLE;
         issue_ready <= 1'b0;
      end else begin
         state <= next_state;
         issue_ready <= (next_state == BFD_IDLE) && ctrl_enable;
      end
   end

   // a taken delayed branch parks its target until the slot has run
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slot_pending <= 1'b0;
         slot_target <= `BFD_ZERO32;
      end else if (state == BFD_CALL) begin
         slot_pending <= 1'b1;
         slot_target <= call_target;
      end else if (take && slot_pending) begin
         slot_pending <= 1'b0;
      end else if (bts_taken) begin
         slot_pending <= 1'b1;
         slot_target <= target;
      end
   end

   // interrupts stay off from the delayed branch until its slot retires
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_hold <= 1'b0;
      end else begin
         int_hold <= (next_state == BFD_CALL) || bts_taken ||
            (slot_pending && !take) || (state == BFD_CALL);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         call_target <= `BFD_ZERO32;
         call_pc <= `BFD_ZERO32;
         procedure_return_reg <= `BFD_ZERO32;
      end else if (exec && hit[OP_CALL]) begin
         call_target <= target;
         call_pc <= issue.pc;
         procedure_return_reg <= issue.pc + `BFD_PC_AHEAD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fetch control towards the pipeline

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flow <= '0;
      end else begin
         flow.redirect <= 1'b0;
         flow.retire <= 1'b0;
         flow.slot_illegal <= 1'b0;
         if (state == BFD_CALL) begin
            flow.retire <= 1'b1;
            flow.fetch_pc <= call_pc + `BFD_PC_STEP;
         end else if (slot_bad) begin
            // the exception logic takes over; the pending target is dropped
            flow.slot_illegal <= 1'b1;
            flow.fetch_pc <= issue.pc;
         end else if (take && slot_pending) begin
            flow.retire <= 1'b1;
            flow.redirect <= 1'b1;
            flow.fetch_pc <= slot_target;
         end else if (bt_taken) begin
            flow.retire <= 1'b1;
            flow.redirect <= 1'b1;
            flow.fetch_pc <= target;
         end else if (exec && !hit[OP_CALL]) begin
            flow.retire <= 1'b1;
            flow.fetch_pc <= issue.pc + `BFD_PC_STEP;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // architectural flags and accumulator; an instruction beats a bus write

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         test_flag <= 1'b0;
         saturation_flag <= 1'b0;
      end else begin
         if (exec && hit[OP_TEST_FLAG_CLEAR]) test_flag <= 1'b0;
         else if (sw_status) test_flag <= wdata_q[`BFD_BIT_TEST];
         if (exec && hit[OP_SATURATION_FLAG_CLEAR]) saturation_flag <= 1'b0;
         else if (sw_status) saturation_flag <= wdata_q[`BFD_BIT_SAT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         accumulator_high <= `BFD_ZERO32;
         accumulator_low <= `BFD_ZERO32;
      end else if (exec && hit[OP_ACCUMULATOR_CLEAR]) begin
         accumulator_high <= `BFD_ZERO32;
         accumulator_low <= `BFD_ZERO32;
      end else begin
         if (sw_acc_hi) accumulator_high <= merge(accumulator_high, wdata_q, wstrb_q);
         if (sw_acc_lo) accumulator_low <= merge(accumulator_low, wdata_q, wstrb_q);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) slot_count <= `BFD_ZERO32;
      else if (slot_bad) slot_count <= slot_count + 32'h0000_0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // register slave

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return res;
   endfunction

   assign wr_commit = !awready && !wready && !bvalid;
   assign wr_known = (aw_addr == `BFD_REG_CTRL) || (aw_addr == `BFD_REG_STATUS) ||
      (aw_addr == `BFD_REG_ACC_HI) || (aw_addr == `BFD_REG_ACC_LO);
   assign sw_status = wr_commit && (aw_addr == `BFD_REG_STATUS) && wstrb_q[0];
   assign sw_acc_hi = wr_commit && (aw_addr == `BFD_REG_ACC_HI);
   assign sw_acc_lo = wr_commit && (aw_addr == `BFD_REG_ACC_LO);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_enable <= `BFD_CTRL_RESET;
      end else if (wr_commit && (aw_addr == `BFD_REG_CTRL) && wstrb_q[0]) begin
         ctrl_enable <= wdata_q[`BFD_BIT_ENABLE];
      end
   end

   // address and data are caught independently, the write lands once both are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= `BFD_RESP_OKAY;
         aw_addr <= '0;
         wdata_q <= `BFD_ZERO32;
         wstrb_q <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_addr <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
            wready <= 1'b0;
         end
         if (wr_commit) begin
            bvalid <= 1'b1;
            bresp <= wr_known ? `BFD_RESP_OKAY : `BFD_RESP_SLVERR;
            awready <= 1'b1;
            wready <= 1'b1;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_value = `BFD_ZERO32;
      rd_known = 1'b1;
      case (araddr)
         `BFD_REG_CTRL: rd_value[`BFD_BIT_ENABLE] = ctrl_enable;
         `BFD_REG_STATUS: begin
            rd_value[`BFD_BIT_TEST] = test_flag;
            rd_value[`BFD_BIT_SAT] = saturation_flag;
            rd_value[`BFD_BIT_SLOT] = slot_pending;
            rd_value[`BFD_BIT_HOLD] = int_hold;
            rd_value[`BFD_BIT_CALL] = (state == BFD_CALL);
         end
         `BFD_REG_PR: rd_value = procedure_return_reg;
         `BFD_REG_ACC_HI: rd_value = accumulator_high;
         `BFD_REG_ACC_LO: rd_value = accumulator_low;
         `BFD_REG_SLOT_CNT: rd_value = slot_count;
         default: rd_known = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= `BFD_ZERO32;
         rresp <= `BFD_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_value;
         rresp <= rd_known ? `BFD_RESP_OKAY : `BFD_RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_call_return: assert property (exec && hit[OP_CALL] |=>
      procedure_return_reg == $past(issue.pc) + `BFD_PC_AHEAD)
      else $error("return address not pc plus four");
   a_call_target: assert property (exec && hit[OP_CALL] |-> ##2
      (slot_pending && slot_target == $past(issue.pc, 2) + `BFD_PC_AHEAD
      + $past(issue.selected_general_register, 2)))
      else $error("register call target wrong");
   a_call_slot: assert property (exec && hit[OP_CALL] |=>
      !issue_ready ##1 (flow.retire && !flow.redirect))
      else $error("register call did not free its slot");
   a_hold_slot: assert property (slot_pending |-> int_hold)
      else $error("interrupts open during delay slot");
   a_slot_branch: assert property (slot_bad |=>
      flow.slot_illegal && !flow.redirect && !slot_pending)
      else $error("branch in slot not flagged");
   a_flag_clear_nop: assert property (exec && hit[OP_BT] && !test_flag &&
      !slot_pending |=> !flow.redirect && flow.fetch_pc == $past(issue.pc) + `BFD_PC_STEP)
      else $error("flag branch taken with flag clear");
   a_bt_target: assert property (bt_taken && !slot_pending |=> flow.redirect &&
      flow.fetch_pc == $past(issue.pc) + `BFD_PC_AHEAD +
      {{23{$past(issue.word[7])}}, $past(issue.word[7:0]), 1'b0})
      else $error("flag branch target wrong");
   a_bts_delay: assert property (bts_taken && !slot_pending |=>
      slot_pending && !flow.redirect && issue_ready)
      else $error("delayed flag branch did not wait for slot");
   a_slot_jump: assert property (take && slot_pending && !is_branch |=>
      flow.redirect && flow.fetch_pc == $past(slot_target))
      else $error("slot did not end in jump");
   a_acc_clear: assert property (exec && hit[OP_ACCUMULATOR_CLEAR] && !sw_status |=>
      accumulator_high == `BFD_ZERO32 && accumulator_low == `BFD_ZERO32 &&
      test_flag == $past(test_flag))
      else $error("accumulator clear wrong");
   a_sat_clear: assert property (exec && hit[OP_SATURATION_FLAG_CLEAR] && !sw_status |=>
      !saturation_flag && test_flag == $past(test_flag))
      else $error("saturation clear wrong");
   a_test_clear: assert property (exec && hit[OP_TEST_FLAG_CLEAR] |=> !test_flag)
      else $error("test clear wrong");

endmodule

//--- test/bfd_fetch_model.sv
// fetch-side model that presents instruction words to the decoder
`timescale 1ns/1ns
module bfd_fetch_model import bfd_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire bfd_issue_type cmd,
   input wire logic go,
   input wire logic [1:0] gap,
   input wire logic issue_ready,
   output bfd_issue_type issue,
   output logic issue_valid
);
   logic [1:0] wait_left;
   logic armed;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed <= 1'b0;
         wait_left <= 2'h0;
         issue_valid <= 1'b0;
         issue <= '0;
      end else if (go) begin
         armed <= 1'b1;
         wait_left <= gap;
         issue <= cmd;
      end else if (armed && wait_left != 2'h0) begin
         // a slow fetch leaves gaps before the word is offered
         wait_left <= wait_left - 2'h1;
      end else if (armed) begin
         armed <= 1'b0;
         issue_valid <= 1'b1;
      end else if (issue_valid && issue_ready) begin
         // released word turns to junk so a late sample cannot pass
         issue_valid <= 1'b0;
         issue <= ~issue;
      end
   end
endmodule

//--- test/branch_and_flag_clear_decode_bench.sv
// self-checking bench for the branch and flag clear decoder
`timescale 1ns/1ns
`include "bfd_cfg.svh"
module branch_and_flag_clear_decode_bench import bfd_pkg::*;;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, issue_valid, issue_ready, go, int_hold;
   logic test_flag, saturation_flag, hold_ev;
   logic [7:0] awaddr, araddr, disp;
   logic [31:0] wdata, rdata, procedure_return_reg, accumulator_high, accumulator_low;
   logic [31:0] d, p, r;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs, gap;
   logic [15:0] rnd;
   bfd_issue_type issue, cmd;
   bfd_flow_type flow, ev;
   int n_fail = 0;
   int check_count = 0;
   int ev_cnt = 0;
   int cycles = 0;
   int i;

   bfd_core #(.ADDR_W(8)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .issue(issue), .issue_valid(issue_valid), .issue_ready(issue_ready),
      .flow(flow), .int_hold(int_hold), .procedure_return_reg(procedure_return_reg),
      .accumulator_high(accumulator_high), .accumulator_low(accumulator_low),
      .test_flag(test_flag), .saturation_flag(saturation_flag));

   bfd_fetch_model i_fetch (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .go(go), .gap(gap),
      .issue_ready(issue_ready), .issue(issue), .issue_valid(issue_valid));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [31:0] bt_tgt(input logic [31:0] a, input logic [7:0] dd);
      return a + 32'h4 + {{23{dd[7]}}, dd, 1'b0};
   endfunction

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dd, output logic [1:0] s);
      awaddr <= a;
      wdata <= dd;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      s = bresp;
      bready <= 1'b0;
      // one idle edge so a following call never re-raises bready in this time step
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] s);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      dd = rdata;
      s = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   // offers one word through the fetch model and waits for its outcome
   task automatic send(input logic [15:0] w, input logic [31:0] a, input logic [31:0] v);
      int n0;
      int k;
      n0 = ev_cnt;
      cmd <= '{word: w, pc: a, selected_general_register: v};
      gap <= rnd[1:0];
      go <= 1'b1;
      rnd = lfsr(rnd);
      @(posedge aclk);
      go <= 1'b0;
      for (k = 0; k < 60 && ev_cnt == n0; k++) @(posedge aclk);
      check("outcome seen", 32'(ev_cnt != n0), 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      if (flow.retire || flow.slot_illegal) begin
         ev <= flow;
         hold_ev <= int_hold;
         ev_cnt <= ev_cnt + 1;
      end
   end

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         summarize();
      end
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, go} = 7'h00;
      {awaddr, araddr, wdata, gap} = '0;
      wstrb = 4'hF;
      cmd = '0;
      rnd = 16'hC358;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`BFD_REG_CTRL, d, rs);
      check("ctrl reset", d, 32'h1);
      rd(`BFD_REG_STATUS, d, rs);
      check("status reset", d, 32'h0);
      rd(8'h18, d, rs);
      check("unmapped resp", 32'(rs), 32'(`BFD_RESP_SLVERR));
      r = {rnd, lfsr(rnd)};
      wr(`BFD_REG_ACC_HI, r, rs);
      wr(`BFD_REG_ACC_LO, ~r, rs);
      rd(`BFD_REG_ACC_LO, d, rs);
      check("acc low", d, ~r);
      check("acc high", accumulator_high, r);
      wr(`BFD_REG_PR, r, rs);
      check("ro write resp", 32'(rs), 32'(`BFD_RESP_SLVERR));
      wr(`BFD_REG_STATUS, 32'h3, rs);
      p = 32'h0000_1000;
      // shares the low byte of the test clear but must leave the flag alone
      send(16'h1008, p, 32'h0);
      check("word kept", 32'(test_flag), 32'h1);
      check("word step", ev.fetch_pc, p + 32'h2);
      send(`BFD_OP_ACCUMULATOR_CLEAR_VAL, p, 32'h0);
      check("acc high", accumulator_high, 32'h0);
      check("acc low", accumulator_low, 32'h0);
      check("test kept", 32'(test_flag), 32'h1);
      check("step", ev.fetch_pc, p + 32'h2);
      send(`BFD_OP_SATURATION_FLAG_CLEAR_VAL, p, 32'h0);
      check("sat", 32'(saturation_flag), 32'h0);
      check("test kept", 32'(test_flag), 32'h1);
      for (i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         disp = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : rnd[7:0];
         p = {15'h0, rnd, 1'b0};
         send({8'h89, disp}, p, 32'h0);
         check("bt redirect", 32'(ev.redirect), 32'h1);
         check("bt target", ev.fetch_pc, bt_tgt(p, disp));
      end
      r = {rnd, 16'h0123};
      p = 32'h0000_4000;
      send({4'h0, rnd[3:0], 8'h03}, p, r);
      check("return reg", procedure_return_reg, p + 32'h4);
      check("call step", ev.fetch_pc, p + 32'h2);
      check("call hold", 32'(hold_ev), 32'h1);
      send(`BFD_OP_SATURATION_FLAG_CLEAR_VAL, p + 32'h2, 32'h0);
      check("call target", ev.fetch_pc, p + 32'h4 + r);
      check("call redirect", 32'(ev.redirect), 32'h1);
      p = 32'h0000_2000;
      send(16'h8D10, p, 32'h0);
      check("bts hold", 32'(hold_ev), 32'h1);
      send(16'h8905, p + 32'h2, 32'h0);
      check("slot illegal", 32'(ev.slot_illegal), 32'h1);
      check("illegal pc", ev.fetch_pc, p + 32'h2);
      send(16'h8DF0, p, 32'h0);
      check("bts step", ev.fetch_pc, p + 32'h2);
      send(`BFD_OP_TEST_FLAG_CLEAR_VAL, p + 32'h2, 32'h0);
      check("bts target", ev.fetch_pc, bt_tgt(p, 8'hF0));
      check("test clear", 32'(test_flag), 32'h0);
      send(16'h8940, p, 32'h0);
      check("bt idle", 32'(ev.redirect), 32'h0);
      check("bt step", ev.fetch_pc, p + 32'h2);
      send(16'h8D40, p, 32'h0);
      check("bts idle hold", 32'(hold_ev), 32'h0);
      rd(`BFD_REG_SLOT_CNT, d, rs);
      check("slot count", d, 32'h1);
      wr(`BFD_REG_CTRL, 32'h0, rs);
      repeat (2) @(posedge aclk);
      check("disabled", 32'(issue_ready), 32'h0);
      wr(`BFD_REG_CTRL, 32'h1, rs);
      summarize();
   end
endmodule
